// ### spst_checker.sv
// concurrent checks on the strand park status ports
`timescale 1ns/1ns
//==========================
// checker
//==========================
module spst_checker #(
	parameter int N = 64
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// strand state
	input wire logic rd_valid_o,
	input wire logic [N-1:0] enable_i,
	input wire logic [63:0] status_o,
	input wire logic [63:0] run_ctl_o,
	input wire logic [N-1:0] strand_park_o,
	input wire logic [N-1:0] strand_issue_en_o,
	input wire logic [N-1:0] software_initiated_restart_i,
	input wire logic [N-1:0] watchdog_restart_i,
	input wire logic [N-1:0] strand_restart_o,
	input wire logic [N-1:0] full_restart_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	run_status_a: assert property ((run_ctl_o & ~status_o) == 0)
		else $error("running strand shows parked");
	disabled_a: assert property ((status_o & ~64'(enable_i)) == 0)
		else $error("disabled strand shows active");
	no_rise_a: assert property ((status_o & ~$past(status_o) & ~run_ctl_o & ~$past(run_ctl_o)) == 0)
		else $error("status rose without run");
	// strand 3 is the one the bench parks while still busy
	park_bound_a: assert property ($fell(run_ctl_o[3]) |-> ##[1:40] !status_o[3])
		else $error("park did not complete");
	early_a: assert property ((~status_o[N-1:0] & $past(status_o[N-1:0]) & ~strand_park_o) == 0)
		else $error("status fell before park");
	issue_off_a: assert property ((strand_park_o & strand_issue_en_o) == 0)
		else $error("parked strand still issues");
	own_restart_a: assert property (strand_restart_o == $past(software_initiated_restart_i | watchdog_restart_i))
		else $error("restart reached other strand");
	all_or_none_a: assert property (full_restart_o == '0 || &full_restart_o)
		else $error("full restart missed a strand");
	boot_a: assert property (full_restart_o[0] |-> ##[0:4] run_ctl_o[N-1:0] == (enable_i & (~enable_i + 1'b1)))
		else $error("boot master not lowest enabled");
	cover property ($fell(status_o[3]));
	cover property (full_restart_o[0]);
	cover property (rd_valid_o);
endmodule
bind spst_top spst_checker #(.N(N)) chk_u (.*);

// ### spst_defines.svh
// constants for the strand park status block
`ifndef SPST_DEFINES_SVH
`define SPST_DEFINES_SVH
`define SPST_ASI_SHARED 8'h41
`define SPST_VA_RUN_RW 64'h0000_0000_0000_0050
`define SPST_VA_STATUS 64'h0000_0000_0000_0058
`define SPST_VA_RUN_W1S 64'h0000_0000_0000_0060
`define SPST_VA_RUN_W1C 64'h0000_0000_0000_0068
`define SPST_NUM_STRANDS 64
`define SPST_PARK_SKID 4
`endif

// ### spst_pkg.sv
// types for the strand park status block
package spst_pkg;
	typedef struct packed {
		logic [63:0] run_q;
		logic [63:0] status_q;
		logic [63:0] parked_q;
		logic [63:0] rd_data_q;
		logic rd_valid_q;
		logic [63:0] strand_rst_q;
		logic [63:0] pwr_rst_q;
		logic booted_q;
	} spst_state_type;
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] asi;
		logic [63:0] va;
		logic [63:0] wdata;
	} spst_req_type;
endpackage

// ### spst_top.sv
// strand run control, park tracking and active-status register
`timescale 1ns/1ns
`include "spst_defines.svh"

//=====================================================
// strand park status top
//=====================================================
module spst_top #(
	parameter int N = `SPST_NUM_STRANDS,
	parameter int SKID = `SPST_PARK_SKID
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic warm_restart_i,
	// alternate space access
	input wire spst_pkg::spst_req_type req_i,
	output logic [63:0] rd_data_o,
	output logic rd_valid_o,
	// strand state
	input wire logic [N-1:0] enable_i,
	input wire logic [N-1:0] standby_i,
	input wire logic [N-1:0] issue_idle_i,
	input wire logic [N-1:0] software_initiated_restart_i,
	input wire logic [N-1:0] watchdog_restart_i,
	output logic [63:0] status_o,
	output logic [63:0] run_ctl_o,
	output logic [N-1:0] strand_park_o,
	output logic [N-1:0] strand_issue_en_o,
	output logic [N-1:0] strand_restart_o,
	output logic [N-1:0] full_restart_o
);
	spst_pkg::spst_state_type s_q;
	spst_pkg::spst_state_type s_d;
	logic [N-1:0] en_q1;
	logic [N-1:0] en_q;
	logic [N-1:0] wrm_q1;
	logic wrm_q;
	logic [N-1:0] lowest;
	logic [N-1:0] wr_new;
	logic [7:0] skid_cnt_q [N];
	logic [N-1:0] skid_done;

	//=====================================================
	// pin synchronisers
	//=====================================================
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			en_q1 <= '0;
			en_q <= '0;
			wrm_q1 <= '0;
			wrm_q <= 1'b0;
		end else begin
			en_q1 <= enable_i;
			en_q <= en_q1;
			wrm_q1 <= {N{warm_restart_i}};
			wrm_q <= wrm_q1[0];
		end
	end

	// lowest enabled strand
	always_comb begin
		lowest = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (en_q[i]) begin
				lowest = '0;
				lowest[i] = 1'b1;
			end
		end
	end

	//=====================================================
	// park skid counters, one per strand
	//=====================================================
	// a strand parks once issue has drained and the skid has run out
	for (genvar g = 0; g < N; g++) begin : g_skid
		always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				skid_cnt_q[g] <= 8'h00;
			end else if (s_q.run_q[g]) begin
				skid_cnt_q[g] <= 8'h00;
			end else if (skid_cnt_q[g] < 8'(SKID)) begin
				skid_cnt_q[g] <= skid_cnt_q[g] + 8'h01;
			end
		end
		assign skid_done[g] = (skid_cnt_q[g] >= 8'(SKID)) &&
			issue_idle_i[g];
	end

	//=====================================================
	// run-control write decode
	//=====================================================
	always_comb begin
		wr_new = s_q.run_q[N-1:0];
		if (req_i.valid && req_i.write &&
			req_i.asi == `SPST_ASI_SHARED) begin
			unique case (req_i.va)
				`SPST_VA_RUN_RW: wr_new = req_i.wdata[N-1:0];
				`SPST_VA_RUN_W1S: wr_new = s_q.run_q[N-1:0] |
					req_i.wdata[N-1:0];
				`SPST_VA_RUN_W1C: wr_new = s_q.run_q[N-1:0] &
					~req_i.wdata[N-1:0];
				default: wr_new = s_q.run_q[N-1:0];
			endcase
		end
		// disabled bits stay 0, writes to them ignored
		wr_new = wr_new & en_q;
	end

	//=====================================================
	// next state
	//=====================================================
	always_comb begin
		s_d = s_q;
		s_d.rd_valid_q = 1'b0;
		s_d.strand_rst_q = '0;
		s_d.pwr_rst_q = '0;
		if (!s_q.booted_q || wrm_q) begin
			// full restart: boot master only
			s_d.run_q = '0;
			s_d.run_q[N-1:0] = lowest;
			s_d.status_q = s_d.run_q;
			s_d.parked_q = ~s_d.run_q;
			s_d.pwr_rst_q[N-1:0] = '1;
			// enables need two edges to settle; keep restarting until then
			s_d.booted_q = (en_q != '0);
		end else begin
			// discard a store that parks every enabled strand
			if ((wr_new & en_q) != '0 || en_q == '0) begin
				s_d.run_q[N-1:0] = wr_new;
			end else begin
				s_d.run_q[N-1:0] = s_q.run_q[N-1:0] & en_q;
			end
			for (int i = 0; i < N; i++) begin
				// standby plays no part in park state
				// new run value used so status never lags run
				if (s_d.run_q[i]) begin
					s_d.parked_q[i] = 1'b0;
				end else if (skid_done[i]) begin
					s_d.parked_q[i] = 1'b1;
				end
				s_d.status_q[i] = en_q[i] &&
					(s_d.run_q[i] || !s_d.parked_q[i]);
			end
			// per-strand restarts never spread
			s_d.strand_rst_q[N-1:0] = software_initiated_restart_i |
				watchdog_restart_i;
		end
		if (req_i.valid && !req_i.write &&
			req_i.asi == `SPST_ASI_SHARED) begin
			s_d.rd_valid_q = 1'b1;
			unique case (req_i.va)
				`SPST_VA_STATUS: s_d.rd_data_q = s_q.status_q;
				`SPST_VA_RUN_RW: s_d.rd_data_q = s_q.run_q;
				default: s_d.rd_data_q = 64'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.parked_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	//=====================================================
	// outputs
	//=====================================================
	assign rd_data_o = s_q.rd_data_q;
	assign rd_valid_o = s_q.rd_valid_q;
	assign status_o = s_q.status_q;
	assign run_ctl_o = s_q.run_q;
	assign strand_park_o = s_q.parked_q[N-1:0];
	// parked strands stop issue; coherency snoops stay outside
	assign strand_issue_en_o = ~s_q.parked_q[N-1:0];
	assign strand_restart_o = s_q.strand_rst_q[N-1:0];
	assign full_restart_o = s_q.pwr_rst_q[N-1:0];
endmodule

// ### tb_top.sv
// self-checking bench for the strand park status block
`timescale 1ns/1ns
module tb_top;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic warm_restart_i = 1'b0;
	spst_pkg::spst_req_type req_i = '0;
	logic [63:0] rd_data_o, status_o, run_ctl_o;
	logic rd_valid_o;
	// strand 1 stays disabled so forced-zero bits are seen
	logic [3:0] enable_i = 4'hD, stby = 4'hA, idle = 4'hF, sw = 4'h0, wd = 4'h0;
	logic [3:0] park, issue_en, restart, full;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	spst_top #(.N(4), .SKID(4)) dut_u (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .warm_restart_i(warm_restart_i),
		.req_i(req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.enable_i(enable_i), .standby_i(stby), .issue_idle_i(idle),
		.software_initiated_restart_i(sw), .watchdog_restart_i(wd),
		.status_o(status_o), .run_ctl_o(run_ctl_o), .strand_park_o(park),
		.strand_issue_en_o(issue_en), .strand_restart_o(restart),
		.full_restart_o(full));
	initial forever #4 clk_sys_i = ~clk_sys_i;
	//==========================
	// helpers
	//==========================
	task automatic ck(input logic [63:0] g, e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [63:0] va, d);
		@(posedge clk_sys_i) req_i <= '{1'b1, w, 8'h41, va, d};
		@(posedge clk_sys_i) req_i.valid <= 1'b0;
		#1 ck(64'(rd_valid_o), 64'(!w));
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	//==========================
	// scenarios
	//==========================
	task automatic boot_test;
		@(posedge clk_sys_i) warm_restart_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		warm_restart_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		acc(1'b0, 64'h58, 64'h0);
		ck(rd_data_o, 64'h1);
		ck(run_ctl_o, 64'h1);
	endtask
	task automatic unpark_test;
		acc(1'b1, 64'h60, 64'hF);
		ck(run_ctl_o, 64'hD);
		acc(1'b0, 64'h58, 64'h0);
		ck(rd_data_o, 64'hD);
	endtask
	task automatic park_test;
		idle <= 4'h7;
		acc(1'b1, 64'h68, 64'h8);
		repeat (12) @(posedge clk_sys_i);
		ck(status_o, 64'hD);
		idle <= 4'hF;
		repeat (12) @(posedge clk_sys_i);
		ck(status_o, 64'h5);
	endtask
	task automatic guard_test;
		acc(1'b1, 64'h50, 64'h0);
		ck(run_ctl_o, 64'h5);
		acc(1'b1, 64'h58, 64'hFF);
		ck(status_o, 64'h5);
		acc(1'b0, 64'h30, 64'h0);
		ck(rd_data_o, 64'h0);
	endtask
	task automatic restart_test;
		@(posedge clk_sys_i) sw <= 4'h1;
		wd <= 4'h4;
		@(posedge clk_sys_i) sw <= 4'h0;
		wd <= 4'h0;
		#1 ck(64'(restart), 64'h5);
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		boot_test;
		unpark_test;
		park_test;
		guard_test;
		restart_test;
		tally_and_finish;
	end
	// the whole sequence needs about a hundred cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 2000) begin
			err_total++;
			tally_and_finish;
		end
	end
endmodule
